/* File: core/cgwp_top.sv */
`timescale 1ns/10ps
module cgwp_top (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // clock gear outputs
    output logic                       gearTick,
    output logic                       prescalerTick,
    output logic                       warmupBusy,
    output cgwp_pkg::cgwp_halt_e       haltStateSel,
    output logic                       stopPinDrive,
    output logic                       externalOscSel,
    // protection and chip-select write gating
    output logic                       protectOn,
    output logic                       csWriteStrobe,
    output logic      [7:0]            csWriteAddr,
    output logic      [7:0]            csWriteData
);
    // ------------------------------------------------------------
    // bus request decode
    // ------------------------------------------------------------
    cgwp_pkg::cgwp_wb_req_s req;
    logic                   ack_r;
    logic                   access;
    logic                   wrLane0;
    logic                   wrEn;
    logic                   blocked;
    logic                   isCs;

    assign req     = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                       adr: wb_adr_i, dat: wb_dat_i};
    assign access  = req.cyc && req.stb && !ack_r;
    assign wrLane0 = access && req.we && req.sel[0];
    assign isCs    = (req.adr >= cgwp_pkg::REG_CS_FIRST)
                  && (req.adr <= cgwp_pkg::REG_CS_LAST);

    // ------------------------------------------------------------
    // protection
    // ------------------------------------------------------------
    logic protect_r;

    always_comb begin
        case (req.adr)
            cgwp_pkg::REG_WARMUP_PRESCALER,
            cgwp_pkg::REG_DIVIDER_SELECT,
            cgwp_pkg::REG_STANDBY_WARMUP,
            cgwp_pkg::REG_PROTECT_STATUS: blocked = protect_r;
            cgwp_pkg::REG_PROTECT_KEY:    blocked = 1'b0;
            default:                      blocked = isCs && protect_r;
        endcase
    end

    assign wrEn = wrLane0 && !blocked;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            protect_r <= cgwp_pkg::RST_PROTECT;
        end else if (wrLane0 && req.adr == cgwp_pkg::REG_PROTECT_KEY) begin
            protect_r <= (req.dat[7:0] != cgwp_pkg::PROTECT_OFF_KEY);
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    cgwp_pkg::cgwp_cfg_s cfg_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r.prescalerSourceSel <= cgwp_pkg::cgwp_pre_e'(cgwp_pkg::RST_PRESCALER);
            cfg_r.gearSel            <= cgwp_pkg::RST_GEAR;
            cfg_r.warmupLengthSel    <= cgwp_pkg::RST_WARMUP_LEN;
            cfg_r.haltStateSel       <= cgwp_pkg::cgwp_halt_e'(cgwp_pkg::RST_HALT_STATE);
            cfg_r.standbyPinDrive    <= cgwp_pkg::RST_PIN_DRIVE;
            cfg_r.externalOscSel     <= cgwp_pkg::RST_EXT_OSC;
        end else if (wrEn) begin
            case (req.adr)
                cgwp_pkg::REG_WARMUP_PRESCALER: begin
                    // bits 7..3 carry the fixed pattern software must write
                    cfg_r.prescalerSourceSel <= cgwp_pkg::cgwp_pre_e'(
                        req.dat[cgwp_pkg::POS_PRESCALER +: 2]);
                end
                cgwp_pkg::REG_DIVIDER_SELECT: begin
                    cfg_r.gearSel <= req.dat[cgwp_pkg::POS_GEAR +: 3];
                end
                cgwp_pkg::REG_STANDBY_WARMUP: begin
                    cfg_r.warmupLengthSel <= req.dat[cgwp_pkg::POS_WARMUP_LEN +: 2];
                    cfg_r.haltStateSel    <= cgwp_pkg::cgwp_halt_e'(
                        req.dat[cgwp_pkg::POS_HALT_STATE +: 2]);
                    cfg_r.standbyPinDrive <= req.dat[cgwp_pkg::POS_PIN_DRIVE];
                end
                cgwp_pkg::REG_PROTECT_STATUS: begin
                    cfg_r.externalOscSel <= req.dat[cgwp_pkg::POS_EXT_OSC];
                end
                default: begin
                    cfg_r <= cfg_r;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // gear divider and warm-up timer
    // ------------------------------------------------------------
    logic gearPulse;
    logic div16Pulse;
    logic warmStart;
    logic warmRunning;

    cgwp_clock_divider u_div (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .gearSel   (cfg_r.gearSel),
        .gearTick  (gearPulse),
        .div16Tick (div16Pulse)
    );

    assign warmStart = wrEn && req.adr == cgwp_pkg::REG_WARMUP_PRESCALER
                    && req.dat[cgwp_pkg::POS_WARMUP_FLAG];

    cgwp_warmup_timer u_warm (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .start     (warmStart),
        .lengthSel (cfg_r.warmupLengthSel),
        .inputTick (1'b1),
        .running   (warmRunning)
    );

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    logic preTick;

    always_comb begin
        case (cfg_r.prescalerSourceSel)
            cgwp_pkg::PRE_FC_DIV16: preTick = div16Pulse;
            default:                preTick = gearPulse;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gearTick      <= 1'b0;
            prescalerTick <= 1'b0;
            warmupBusy    <= 1'b0;
        end else begin
            gearTick      <= gearPulse;
            prescalerTick <= preTick;
            warmupBusy    <= warmRunning;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            haltStateSel   <= cgwp_pkg::cgwp_halt_e'(cgwp_pkg::RST_HALT_STATE);
            stopPinDrive   <= cgwp_pkg::RST_PIN_DRIVE;
            externalOscSel <= cgwp_pkg::RST_EXT_OSC;
            protectOn      <= cgwp_pkg::RST_PROTECT;
        end else begin
            haltStateSel   <= cfg_r.haltStateSel;
            stopPinDrive   <= cfg_r.standbyPinDrive
                           && cfg_r.haltStateSel == cgwp_pkg::HALT_STOP;
            externalOscSel <= cfg_r.externalOscSel;
            protectOn      <= protect_r;
        end
    end

    // chip-select writes pass only while unprotected
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            csWriteStrobe <= 1'b0;
            csWriteAddr   <= '0;
            csWriteData   <= '0;
        end else begin
            csWriteStrobe <= wrEn && isCs;
            if (wrEn && isCs) begin
                csWriteAddr <= req.adr;
                csWriteData <= req.dat[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    logic [7:0] rdByte;

    always_comb begin
        case (req.adr)
            cgwp_pkg::REG_WARMUP_PRESCALER: begin
                rdByte = cgwp_pkg::FIX_WARMUP_PRESCALER;
                rdByte[cgwp_pkg::POS_WARMUP_FLAG] = warmRunning;
                rdByte[cgwp_pkg::POS_PRESCALER +: 2] = cfg_r.prescalerSourceSel;
            end
            cgwp_pkg::REG_DIVIDER_SELECT: begin
                rdByte = '0;
                rdByte[cgwp_pkg::POS_GEAR +: 3] = cfg_r.gearSel;
            end
            cgwp_pkg::REG_STANDBY_WARMUP: begin
                rdByte = cgwp_pkg::FIX_STANDBY_WARMUP;
                rdByte[cgwp_pkg::POS_WARMUP_LEN +: 2] = cfg_r.warmupLengthSel;
                rdByte[cgwp_pkg::POS_HALT_STATE +: 2] = cfg_r.haltStateSel;
                rdByte[cgwp_pkg::POS_PIN_DRIVE]       = cfg_r.standbyPinDrive;
            end
            cgwp_pkg::REG_PROTECT_STATUS: begin
                rdByte = cgwp_pkg::FIX_PROTECT_STATUS;
                rdByte[cgwp_pkg::POS_PROTECT] = protect_r;
                rdByte[cgwp_pkg::POS_EXT_OSC] = cfg_r.externalOscSel;
            end
            default: begin
                rdByte = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r    <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            ack_r    <= access;
            wb_dat_o <= access ? {24'h00_0000, rdByte} : '0;
        end
    end

    assign wb_ack_o = ack_r;
endmodule

/* File: core/cgwp_pkg.sv */
package cgwp_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one byte register at each consecutive address)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_WARMUP_PRESCALER = 8'h00_E0;
    localparam logic [7:0] REG_DIVIDER_SELECT   = 8'h00_E1;
    localparam logic [7:0] REG_STANDBY_WARMUP   = 8'h00_E2;
    localparam logic [7:0] REG_PROTECT_STATUS   = 8'h00_E3;
    localparam logic [7:0] REG_PROTECT_KEY      = 8'h00_E4;
    localparam logic [7:0] REG_CS_FIRST         = 8'h00_C0;
    localparam logic [7:0] REG_CS_LAST          = 8'h00_CF;

    localparam logic [7:0] PROTECT_OFF_KEY      = 8'h00_1F;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0] RST_PRESCALER        = 2'h0;
    localparam logic [2:0] RST_GEAR             = 3'h4;
    localparam logic [1:0] RST_WARMUP_LEN       = 2'h2;
    localparam logic [1:0] RST_HALT_STATE       = 2'h3;
    localparam logic       RST_PIN_DRIVE        = 1'b0;
    localparam logic       RST_EXT_OSC          = 1'b0;
    localparam logic       RST_PROTECT          = 1'b0;

    // fixed read patterns of always-write bits
    localparam logic [7:0] FIX_WARMUP_PRESCALER = 8'h00_A0;
    localparam logic [7:0] FIX_STANDBY_WARMUP   = 8'h00_00;
    localparam logic [7:0] FIX_PROTECT_STATUS   = 8'h00_23;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_WARMUP_FLAG = 2;
    localparam int POS_PRESCALER   = 0;
    localparam int POS_GEAR        = 0;
    localparam int POS_WARMUP_LEN  = 4;
    localparam int POS_HALT_STATE  = 2;
    localparam int POS_PIN_DRIVE   = 0;
    localparam int POS_EXT_OSC     = 2;
    localparam int POS_PROTECT     = 7;

    // ------------------------------------------------------------
    // warm-up lengths as exponents of two
    // ------------------------------------------------------------
    localparam int WARMUP_EXP_SHORT = 8;
    localparam int WARMUP_EXP_MID   = 14;
    localparam int WARMUP_EXP_LONG  = 16;
    localparam int WARMUP_CNT_W     = 17;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HALT_RSVD,
        HALT_STOP,
        HALT_IDLE_A,
        HALT_IDLE_B
    } cgwp_halt_e;

    typedef enum logic [1:0] {
        PRE_CPU_CLOCK,
        PRE_RSVD_A,
        PRE_FC_DIV16,
        PRE_RSVD_B
    } cgwp_pre_e;

    typedef struct packed {
        logic [2:0]  gearSel;
        cgwp_pre_e   prescalerSourceSel;
        logic [1:0]  warmupLengthSel;
        cgwp_halt_e  haltStateSel;
        logic        standbyPinDrive;
        logic        externalOscSel;
    } cgwp_cfg_s;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } cgwp_wb_req_s;

endpackage

/* File: core/cgwp_warmup_timer.sv */
`timescale 1ns/10ps
module cgwp_warmup_timer #(
    parameter int CNT_W = cgwp_pkg::WARMUP_CNT_W
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // control
    input  wire logic             start,
    input  wire logic [1:0]       lengthSel,
    input  wire logic             inputTick,
    // status
    output logic                  running
);
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] target;
    logic             running_r;

    always_comb begin
        case (lengthSel)
            2'h1:    target = CNT_W'(1) << cgwp_pkg::WARMUP_EXP_SHORT;
            2'h2:    target = CNT_W'(1) << cgwp_pkg::WARMUP_EXP_MID;
            2'h3:    target = CNT_W'(1) << cgwp_pkg::WARMUP_EXP_LONG;
            default: target = CNT_W'(1) << cgwp_pkg::WARMUP_EXP_SHORT;
        endcase
    end

    // counts input periods, clears running at the selected length
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r   <= '0;
            running_r <= 1'b0;
        end else if (start) begin
            count_r   <= '0;
            running_r <= 1'b1;
        end else if (running_r && inputTick) begin
            if (count_r + CNT_W'(1) >= target) begin
                running_r <= 1'b0;
            end
            count_r <= count_r + CNT_W'(1);
        end
    end

    assign running = running_r;
endmodule

/* File: core/cgwp_clock_divider.sv */
`timescale 1ns/10ps
module cgwp_clock_divider #(
    parameter int DIV_W = 4
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // ratio as a power of two
    input  wire logic [2:0] gearSel,
    // enable pulses
    output logic            gearTick,
    output logic            div16Tick
);
    logic [DIV_W-1:0] count_r;
    logic [DIV_W-1:0] mask;

    always_comb begin
        case (gearSel)
            3'h0:    mask = DIV_W'(0);
            3'h1:    mask = DIV_W'(1);
            3'h2:    mask = DIV_W'(3);
            3'h3:    mask = DIV_W'(7);
            3'h4:    mask = DIV_W'(15);
            default: mask = DIV_W'(15);
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_r + DIV_W'(1);
        end
    end

    assign gearTick  = (count_r & mask) == mask;
    assign div16Tick = &count_r;
endmodule

/* File: tb/cgwp_top_monitor.sv */
`timescale 1ns/10ps
module cgwp_top_monitor (
    // clock and reset
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    // bus
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_we_i,
    input wire logic [3:0]           wb_sel_i,
    input wire logic [7:0]           wb_adr_i,
    input wire logic [31:0]          wb_dat_i,
    input wire logic                 wb_ack_o,
    // status
    input wire logic                 warmupBusy,
    input wire cgwp_pkg::cgwp_halt_e haltStateSel,
    input wire logic                 stopPinDrive,
    input wire logic                 protectOn,
    input wire logic                 csWriteStrobe
);
    logic take;
    logic wrE;
    logic csHit;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wrE = take && wb_we_i && wb_sel_i[0];
    assign csHit = wb_adr_i >= cgwp_pkg::REG_CS_FIRST && wb_adr_i <= cgwp_pkg::REG_CS_LAST;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_ack_next: assert property (take |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_key_off: assert property (wrE && wb_adr_i == cgwp_pkg::REG_PROTECT_KEY
        && wb_dat_i[7:0] == cgwp_pkg::PROTECT_OFF_KEY |-> ##2 !protectOn)
        else $error("key did not clear protection");
    a_key_on: assert property (wrE && wb_adr_i == cgwp_pkg::REG_PROTECT_KEY
        && wb_dat_i[7:0] != cgwp_pkg::PROTECT_OFF_KEY |-> ##2 protectOn)
        else $error("other key did not set protection");
    a_cs_blocked: assert property (wrE && csHit && protectOn
        |-> ##1 !csWriteStrobe ##1 !csWriteStrobe)
        else $error("protected chip-select write passed");
    a_cs_passed: assert property (wrE && csHit && !protectOn |-> ##[1:2] csWriteStrobe)
        else $error("chip-select write lost");
    a_cs_pulse: assert property (csWriteStrobe |=> !csWriteStrobe)
        else $error("chip-select strobe too long");
    a_warm_start: assert property (wrE && !protectOn && wb_dat_i[2]
        && wb_adr_i == cgwp_pkg::REG_WARMUP_PRESCALER |-> ##2 warmupBusy)
        else $error("warm-up did not start");
    a_warm_min: assert property ($rose(warmupBusy) |-> warmupBusy[*8])
        else $error("warm-up ended too soon");
    a_pin_stop: assert property (stopPinDrive |-> haltStateSel == cgwp_pkg::HALT_STOP)
        else $error("pin drive outside stop");
endmodule

bind cgwp_top cgwp_top_monitor u_cgwp_top_monitor (
    .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .warmupBusy(warmupBusy), .haltStateSel(haltStateSel),
    .stopPinDrive(stopPinDrive), .protectOn(protectOn), .csWriteStrobe(csWriteStrobe)
);

/* File: tb/cgwp_top_tb.sv */
`timescale 1ns/10ps
module cgwp_top_tb;
    logic                 sysClk = 1'b0;
    logic                 rstN = 1'b0;
    logic                 wbCyc = 1'b0;
    logic                 wbStb = 1'b0;
    logic                 wbWe = 1'b0;
    logic [7:0]           wbAdr = 8'h00;
    logic [31:0]          wbDat = 32'h0000_0000;
    logic [31:0]          wbRdat;
    logic                 wbAck;
    logic                 gearTick;
    logic                 prescalerTick;
    logic                 warmupBusy;
    cgwp_pkg::cgwp_halt_e haltStateSel;
    logic                 stopPinDrive;
    logic                 externalOscSel;
    logic                 protectOn;
    logic                 csWriteStrobe;
    logic [7:0]           csWriteAddr;
    logic [7:0]           csWriteData;
    logic [15:0]          csLast;
    int                   csCount = 0;
    int                   busyRun = 0;
    int                   busyLen = 0;
    int                   cycles = 0;
    int                   badCount = 0;
    int                   totalChecks = 0;

    always #5 sysClk = ~sysClk;

    cgwp_top u_cgwp_top (
        .sys_clk(sysClk), .rst_n(rstN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_sel_i(4'h1), .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_dat_o(wbRdat),
        .wb_ack_o(wbAck), .gearTick(gearTick), .prescalerTick(prescalerTick),
        .warmupBusy(warmupBusy), .haltStateSel(haltStateSel), .stopPinDrive(stopPinDrive),
        .externalOscSel(externalOscSel), .protectOn(protectOn),
        .csWriteStrobe(csWriteStrobe), .csWriteAddr(csWriteAddr), .csWriteData(csWriteData)
    );

    // ----------------------------------------
    // watchers and run limit
    // ----------------------------------------
    always @(posedge sysClk) begin
        cycles++;
        if (csWriteStrobe === 1'b1) begin
            csCount++;
            csLast = {csWriteAddr, csWriteData};
        end
        if (warmupBusy === 1'b1) busyRun++;
        else if (busyRun != 0) begin
            busyLen = busyRun;
            busyRun = 0;
        end
        if (cycles == 95000) begin
            badCount++;
            finish_test();
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge sysClk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDat <= {24'h0, dat};
        do begin
            @(posedge sysClk);
            n++;
        end while (wbAck !== 1'b1 && n < 16);
        rd = wbRdat;
        if (n >= 16) chk(32'h0, 32'h1);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [31:0] d;
        bus(1'b1, adr, dat, d);
        repeat (2) @(posedge sysClk);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, adr, 8'h00, d);
        chk(d, exp);
    endtask

    task automatic period(input bit pre, output int p);
        int n;
        n = 0;
        p = 0;
        @(posedge sysClk);
        while ((pre ? prescalerTick : gearTick) !== 1'b1 && n < 64) begin
            @(posedge sysClk);
            n++;
        end
        do begin
            @(posedge sysClk);
            p++;
        end while ((pre ? prescalerTick : gearTick) !== 1'b1 && p < 64);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd(8'hE0, 32'h0000_00A0);
        rd(8'hE1, 32'h0000_0004);
        rd(8'hE2, 32'h0000_002C);
        rd(8'hE3, 32'h0000_0023);
        rd(8'h50, 32'h0000_0000);
        chk({31'h0, protectOn}, 32'h0);
    endtask

    task automatic t_gear();
        int p;
        for (int g = 0; g < 6; g++) begin
            wr(8'hE1, 8'(g));
            repeat (40) @(posedge sysClk);
            period(1'b0, p);
            chk(p, g < 5 ? 1 << g : 16);
        end
    endtask

    task automatic t_prescaler();
        int p;
        wr(8'hE1, 8'h00);
        wr(8'hE0, 8'hA2);
        repeat (40) @(posedge sysClk);
        period(1'b1, p);
        chk(p, 16);
        chk({31'h0, warmupBusy}, 32'h0);
        wr(8'hE0, 8'hA0);
        repeat (40) @(posedge sysClk);
        period(1'b1, p);
        chk(p, 1);
        wr(8'hE0, 8'hA3);
        repeat (40) @(posedge sysClk);
        period(1'b1, p);
        chk(p, 1);
    endtask

    task automatic t_warmup();
        int n;
        for (int c = 0; c < 4; c++) begin
            wr(8'hE2, 8'h0C | 8'(c << 4));
            wr(8'hE0, 8'hA4);
            if (c == 1) rd(8'hE0, 32'h0000_00A4);
            n = 0;
            while (warmupBusy !== 1'b0 && n < 70000) begin
                @(posedge sysClk);
                n++;
            end
            repeat (3) @(posedge sysClk);
            chk(busyLen, 1 << (c < 2 ? 8 : c == 2 ? 14 : 16));
            rd(8'hE0, 32'h0000_00A0);
        end
    endtask

    task automatic t_halt();
        for (int h = 1; h < 4; h++) begin
            wr(8'hE2, 8'h21 | 8'(h << 2));
            chk({30'h0, haltStateSel}, h);
            chk({31'h0, stopPinDrive}, h == 1);
        end
        wr(8'hE2, 8'h24);
        chk({31'h0, stopPinDrive}, 32'h0);
    endtask

    task automatic t_protect();
        int n0;
        wr(8'hE1, 8'h02);
        wr(8'hE4, 8'h00);
        chk({31'h0, protectOn}, 32'h1);
        rd(8'hE3, 32'h0000_00A3);
        wr(8'hE1, 8'h01);
        rd(8'hE1, 32'h0000_0002);
        wr(8'hE3, 8'h27);
        chk({31'h0, externalOscSel}, 32'h0);
        n0 = csCount;
        wr(8'hC5, 8'h5A);
        chk(csCount, n0);
        wr(8'hE4, 8'h1F);
        chk({31'h0, protectOn}, 32'h0);
        wr(8'hC5, 8'h5A);
        chk(csCount, n0 + 1);
        chk({16'h0, csLast}, 32'h0000_C55A);
        wr(8'hE3, 8'h27);
        chk({31'h0, externalOscSel}, 32'h1);
        rd(8'hE3, 32'h0000_0027);
        wr(8'hE1, 8'h01);
        rd(8'hE1, 32'h0000_0001);
    endtask

    initial begin
        repeat (20) @(posedge sysClk);
        rstN <= 1'b1;
        t_reset();
        t_gear();
        t_prescaler();
        t_halt();
        t_protect();
        t_warmup();
        finish_test();
    end
endmodule
